// *** rtl/blc_loader.sv ***
// Boot sequencer and image loader for one processor tile.
// Assumes OTP answers a read in the same core clock as the strobe, and a quad-SPI flash on the
// link clock port; the flash clock is the link clock divided by two.
`timescale 1ns/1ps
module blc_loader
   import blc_pkg::*;
#(
   parameter int OTP_AW = 11,
   parameter logic [10:0] SEC_ROW = 11'h7FF,
   parameter int INT_RESET_CYC = BLC_INT_RESET_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   output logic otp_rd_o,
   output logic [OTP_AW-1:0] otp_addr_o,
   input wire logic [31:0] otp_data_i,
   output blc_ram_wr_t ram_wr_o,
   output logic [31:0] security_o,
   output logic run_o,
   output logic boot_fail_o,
   output logic gpio_pull_down_o,
   output logic qspi_cs_n_o,
   output logic qspi_sclk_o,
   output logic [3:0] qspi_dq_o,
   output logic [3:0] qspi_dq_oe_n_o,
   input wire logic [3:0] qspi_dq_i
);
   if (OTP_AW < 2 || OTP_AW > 11 || INT_RESET_CYC < 1 || INT_RESET_CYC > 65535) begin : g_chk
      $error("blc_loader: unsupported parameter value");
   end

   function automatic logic [31:0] blc_crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ BLC_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : blc_crc_byte

   // Core domain
   typedef enum logic [2:0] {C_SECRD, C_SECLD, C_DELAY, C_LEN, C_PROG, C_CHK, C_RUN, C_FAIL} blc_cst_t;
   blc_cst_t st, next_st;
   logic [15:0] cnt, next_cnt;
   logic [31:0] word, next_word;
   logic [1:0] bidx, next_bidx;
   logic [31:0] crc, next_crc;
   logic [31:0] wcnt, next_wcnt;
   logic [BLC_RAM_AW-1:0] addr, next_addr;
   blc_ram_wr_t ram, next_ram;
   logic otp_rd, next_otp_rd;
   logic [OTP_AW-1:0] otp_addr, next_otp_addr;
   logic [31:0] sec, next_sec;
   logic run, next_run;
   logic fail, next_fail;
   logic go, next_go;
   logic [31:0] obuf, next_obuf;
   logic [1:0] oidx, next_oidx;
   logic ovld, next_ovld;
   logic pd;
   logic req_s1, req_s2, req_s3;
   logic bv;
   logic [7:0] bd;
   logic [31:0] nw;

   // Link domain
   typedef enum logic [2:0] {L_IDLE, L_HDR, L_DUMMY, L_DATA, L_WAIT} blc_lst_t;
   blc_lst_t lst, next_lst;
   blc_qspi_t q, next_q;
   logic [31:0] lsh, next_lsh;
   logic [5:0] lcnt, next_lcnt;
   logic [1:0] rb, next_rb;
   logic [1:0] mk, next_mk;
   logic nsel, next_nsel;
   logic [3:0] lnib, next_lnib;
   logic [7:0] lbyte, next_lbyte;
   logic req_tog, next_req_tog;
   logic [3:0] dq_s1, dq_s2;
   logic go_s1, go_s2, ack_s1, ack_s2;

   wire logic src_otp = sec[BLC_SEC_BOOT_BIT];
   wire logic loading = (st == C_LEN) || (st == C_PROG) || (st == C_CHK);

   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_word = word;
      next_bidx = bidx;
      next_crc = crc;
      next_wcnt = wcnt;
      next_addr = addr;
      next_ram = '0;
      next_otp_rd = 1'b0;
      next_otp_addr = otp_addr;
      next_sec = sec;
      next_run = run;
      next_fail = fail;
      next_go = go;
      next_obuf = obuf;
      next_oidx = oidx;
      next_ovld = ovld;
      bv = 1'b0;
      bd = 8'h00;
      nw = {bd, word[31:8]};
      // Byte source: OTP words split low byte first, or flash bytes
      if (src_otp) begin
         if (loading && ovld) begin
            bv = 1'b1;
            bd = obuf[8*oidx +: 8];
            next_oidx = oidx + 2'h1;
            if (oidx == 2'h3) begin
               next_ovld = 1'b0;
            end
         end else if (loading && !otp_rd) begin
            next_otp_rd = 1'b1;
         end
         if (otp_rd && loading) begin
            next_obuf = otp_data_i;
            next_ovld = 1'b1;
            next_oidx = 2'h0;
            next_otp_addr = otp_addr + 1'b1;
         end
      end else begin
         bv = loading && (req_s2 != req_s3);
         bd = lbyte;
      end
      nw = {bd, word[31:8]};
      case (st)
         C_SECRD: begin
            next_otp_rd = 1'b1;
            next_otp_addr = SEC_ROW[OTP_AW-1:0];
            next_st = C_SECLD;
         end
         C_SECLD: begin
            next_sec = otp_data_i;
            next_cnt = 16'h0000;
            next_st = C_DELAY;
         end
         C_DELAY: begin
            next_cnt = cnt + 16'h0001;
            if (cnt == 16'(INT_RESET_CYC - 1)) begin
               next_st = C_LEN;
               next_go = !src_otp;
               next_otp_addr = '0;
               next_bidx = 2'h0;
               next_crc = BLC_CRC_INIT;
               next_addr = BLC_RAM_BASE;
            end
         end
         C_LEN, C_PROG, C_CHK: begin
            if (bv) begin
               next_word = nw;
               next_bidx = bidx + 2'h1;
               if (st != C_CHK) begin
                  next_crc = blc_crc_byte(crc, bd);
               end
               if (st == C_PROG) begin
                  next_ram = '{we: 1'b1, addr: addr, data: bd};
                  next_addr = addr + 1'b1;
               end
               if (bidx == 2'h3) begin
                  case (st)
                     C_LEN: begin
                        next_wcnt = nw;
                        if (nw == 32'h00000000) begin
                           next_st = C_CHK;
                        end else if (nw > 32'(1 << (BLC_RAM_AW - 2))) begin
                           next_go = 1'b0;
                           next_fail = 1'b1;
                           next_st = C_FAIL;
                        end else begin
                           next_st = C_PROG;
                        end
                     end
                     C_PROG: begin
                        next_wcnt = wcnt - 32'h00000001;
                        if (wcnt == 32'h00000001) begin
                           next_st = C_CHK;
                        end
                     end
                     default: begin
                        next_go = 1'b0;
                        if (nw == BLC_CRC_BYPASS || nw == ~crc) begin
                           next_run = 1'b1;
                           next_st = C_RUN;
                        end else begin
                           next_fail = 1'b1;
                           next_st = C_FAIL;
                        end
                     end
                  endcase
               end
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= C_SECRD;
         cnt <= 16'h0000;
         word <= 32'h00000000;
         bidx <= 2'h0;
         crc <= BLC_CRC_INIT;
         wcnt <= 32'h00000000;
         addr <= BLC_RAM_BASE;
         ram <= '0;
         otp_rd <= 1'b0;
         otp_addr <= '0;
         sec <= 32'h00000000;
         run <= 1'b0;
         fail <= 1'b0;
         go <= 1'b0;
         obuf <= 32'h00000000;
         oidx <= 2'h0;
         ovld <= 1'b0;
         pd <= 1'b1;
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         word <= next_word;
         bidx <= next_bidx;
         crc <= next_crc;
         wcnt <= next_wcnt;
         addr <= next_addr;
         ram <= next_ram;
         otp_rd <= next_otp_rd;
         otp_addr <= next_otp_addr;
         sec <= next_sec;
         run <= next_run;
         fail <= next_fail;
         go <= next_go;
         obuf <= next_obuf;
         oidx <= next_oidx;
         ovld <= next_ovld;
         pd <= 1'b0;
         req_s1 <= req_tog;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
      end
   end

   // Flash side: command and address on DQ0, dummy clocks, then nibbles high first
   always_comb begin
      next_lst = lst;
      next_q = q;
      next_lsh = lsh;
      next_lcnt = lcnt;
      next_rb = rb;
      next_nsel = nsel;
      next_lnib = lnib;
      next_lbyte = lbyte;
      next_req_tog = req_tog;
      next_mk = {mk[0], 1'b0};
      case (lst)
         L_IDLE: begin
            if (go_s2) begin
               next_q = '{cs_n: 1'b0, sclk: 1'b0, dq: {3'h0, BLC_QSPI_CMD[7]}, oe_n: BLC_OE_N_CMD};
               next_lsh = {BLC_QSPI_CMD, BLC_QSPI_ADDR};
               next_lcnt = BLC_HDR_BITS - 6'h01;
               next_nsel = 1'b0;
               next_lst = L_HDR;
            end
         end
         L_HDR, L_DUMMY: begin
            next_q.sclk = !q.sclk;
            if (q.sclk) begin
               next_lsh = {lsh[30:0], 1'b0};
               next_q.dq = {3'h0, lsh[30]};
               next_lcnt = lcnt - 6'h01;
               if (lcnt == 6'h00) begin
                  next_q.oe_n = BLC_OE_N_IDLE;
                  next_lcnt = BLC_DUMMY_CYC - 6'h01;
                  next_rb = 2'h0;
                  next_lst = (lst == L_HDR) ? L_DUMMY : L_DATA;
               end
            end
         end
         L_DATA: begin
            if (q.sclk) begin
               next_q.sclk = 1'b0;
            end else if (rb != 2'h2) begin
               next_q.sclk = 1'b1;
               next_rb = rb + 2'h1;
               next_mk[0] = 1'b1;
            end
            if (mk[1]) begin
               next_nsel = !nsel;
               next_lnib = dq_s2;
               if (nsel) begin
                  next_lbyte = {lnib, dq_s2};
                  next_req_tog = !req_tog;
                  next_lst = L_WAIT;
               end
            end
         end
         default: begin
            if (ack_s2 == req_tog) begin
               next_rb = 2'h0;
               next_lst = L_DATA;
            end
         end
      endcase
      if (!go_s2) begin
         next_q = '{cs_n: 1'b1, sclk: 1'b0, dq: 4'h0, oe_n: BLC_OE_N_IDLE};
         next_lst = L_IDLE;
      end
   end

   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lst <= L_IDLE;
         q <= '{cs_n: 1'b1, sclk: 1'b0, dq: 4'h0, oe_n: BLC_OE_N_IDLE};
         lsh <= 32'h00000000;
         lcnt <= 6'h00;
         rb <= 2'h0;
         mk <= 2'h0;
         nsel <= 1'b0;
         lnib <= 4'h0;
         lbyte <= 8'h00;
         req_tog <= 1'b0;
         dq_s1 <= 4'h0;
         dq_s2 <= 4'h0;
         go_s1 <= 1'b0;
         go_s2 <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         lst <= next_lst;
         q <= next_q;
         lsh <= next_lsh;
         lcnt <= next_lcnt;
         rb <= next_rb;
         mk <= next_mk;
         nsel <= next_nsel;
         lnib <= next_lnib;
         lbyte <= next_lbyte;
         req_tog <= next_req_tog;
         dq_s1 <= qspi_dq_i;
         dq_s2 <= dq_s1;
         go_s1 <= go;
         go_s2 <= go_s1;
         ack_s1 <= req_s3;
         ack_s2 <= ack_s1;
      end
   end

   assign otp_rd_o = otp_rd;
   assign otp_addr_o = otp_addr;
   assign ram_wr_o = ram;
   assign security_o = sec;
   assign run_o = run;
   assign boot_fail_o = fail;
   assign gpio_pull_down_o = pd;
   assign qspi_cs_n_o = q.cs_n;
   assign qspi_sclk_o = q.sclk;
   assign qspi_dq_o = q.dq;
   assign qspi_dq_oe_n_o = q.oe_n;
endmodule : blc_loader

// *** rtl/blc_pkg.sv ***
// Constants and carrier types for the boot image loader.
// Assumes a 20 MHz core clock and a byte-wide RAM write port.
package blc_pkg;
   localparam int BLC_CORE_CLK_MHZ = 20;
   localparam int BLC_INT_RESET_US = 15;
   localparam int BLC_INT_RESET_CYC = BLC_INT_RESET_US * BLC_CORE_CLK_MHZ;
   localparam logic [31:0] BLC_CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] BLC_CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] BLC_CRC_BYPASS = 32'h0D15AB1E;
   localparam int BLC_SEC_BOOT_BIT = 5;
   localparam int BLC_RAM_AW = 17;
   localparam logic [16:0] BLC_RAM_BASE = 17'h00000;
   localparam logic [7:0] BLC_QSPI_CMD = 8'h6B;
   localparam logic [23:0] BLC_QSPI_ADDR = 24'h000000;
   localparam logic [5:0] BLC_HDR_BITS = 6'h20;
   localparam logic [5:0] BLC_DUMMY_CYC = 6'h08;
   localparam logic [3:0] BLC_OE_N_IDLE = 4'hF;
   localparam logic [3:0] BLC_OE_N_CMD = 4'hE;

   typedef struct packed {
      logic we;
      logic [BLC_RAM_AW-1:0] addr;
      logic [7:0] data;
   } blc_ram_wr_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic [3:0] dq;
      logic [3:0] oe_n;
   } blc_qspi_t;
endpackage : blc_pkg

// *** test/blc_flash_model.sv ***
// Quad-SPI boot flash model: serves img on fast-read clocks.
// Assumes 32 command/address clocks and 8 dummy clocks.
`timescale 1ns/1ps
module blc_flash_model (
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic dq0_i,
   output logic [3:0] dq_o
);
   logic [7:0] img [0:63];
   int rises = 0;
   int nib;
   logic [31:0] hdr = 32'h00000000;
   initial dq_o = 4'h0;
   always @(negedge cs_n_i) rises = 0;
   // Command and address bits are captured on the first 32 rising clocks
   always @(posedge sclk_i) begin
      if (!cs_n_i) begin
         if (rises < 32) hdr = {hdr[30:0], dq0_i};
         rises = rises + 1;
      end
   end
   // Data changes after a falling edge, high nibble first
   always @(negedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         dq_o <= ~dq_o;
      end else if (rises >= 40) begin
         nib = rises - 40;
         dq_o <= nib[0] ? img[nib / 2][3:0] : img[nib / 2][7:4];
      end
   end
endmodule : blc_flash_model

// *** test/blc_loader_sva.sv ***
// Checker for the boot image loader outputs.
// Bound onto blc_loader; sees only its ports.
`timescale 1ns/1ps
module blc_loader_chk
   import blc_pkg::*;
#(
   parameter int OTP_AW = 11,
   parameter logic [10:0] SEC_ROW = 11'h7FF,
   parameter int INT_RESET_CYC = BLC_INT_RESET_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic otp_rd_o,
   input wire logic [OTP_AW-1:0] otp_addr_o,
   input wire blc_ram_wr_t ram_wr_o,
   input wire logic [31:0] security_o,
   input wire logic run_o,
   input wire logic boot_fail_o,
   input wire logic gpio_pull_down_o,
   input wire logic qspi_cs_n_o,
   input wire logic [3:0] qspi_dq_oe_n_o
);
   logic [15:0] cyc, next_cyc;
   logic [16:0] nwr, next_nwr;
   localparam int BOOT_MAX_CYC = 150 * BLC_CORE_CLK_MHZ;
   logic img_rd, next_img_rd;
   logic flash_seen, next_flash_seen;
   logic img_req;
   always_comb begin
      img_req = otp_rd_o && (otp_addr_o != SEC_ROW);
      next_cyc = (cyc == 16'hFFFF) ? cyc : cyc + 16'h0001;
      next_nwr = ram_wr_o.we ? nwr + 17'h00001 : nwr;
      next_img_rd = img_rd || img_req;
      next_flash_seen = flash_seen || !qspi_cs_n_o;
   end
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cyc <= 16'h0000;
         nwr <= 17'h00000;
         img_rd <= 1'b0;
         flash_seen <= 1'b0;
      end else begin
         cyc <= next_cyc;
         nwr <= next_nwr;
         img_rd <= next_img_rd;
         flash_seen <= next_flash_seen;
      end
   end
   property p_rst_quiet;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         $rose(rst_n_i) |-> gpio_pull_down_o && !run_o && !boot_fail_o && !otp_rd_o && !ram_wr_o.we;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("busy out of reset");
   property p_sec_first;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         $rose(rst_n_i) |-> ##[1:2] (otp_rd_o && otp_addr_o == SEC_ROW);
   endproperty
   a_sec_first: assert property (p_sec_first) else $error("security row not read first");
   property p_boot_wait;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (img_req || ram_wr_o.we || !qspi_cs_n_o) |-> cyc >= 16'(INT_RESET_CYC);
   endproperty
   a_boot_wait: assert property (p_boot_wait) else $error("boot before internal reset");
   // First image access must come before the longest internal reset allowed
   property p_boot_late;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (img_req && !img_rd) || (!qspi_cs_n_o && !flash_seen) |-> cyc <= 16'(BOOT_MAX_CYC);
   endproperty
   a_boot_late: assert property (p_boot_late) else $error("boot after internal reset limit");
   property p_otp_src;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         img_req && !img_rd |-> security_o[BLC_SEC_BOOT_BIT] && otp_addr_o == '0;
   endproperty
   a_otp_src: assert property (p_otp_src) else $error("bad otp image start");
   property p_flash_src;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         !qspi_cs_n_o |-> !security_o[BLC_SEC_BOOT_BIT] && !img_rd;
   endproperty
   a_flash_src: assert property (p_flash_src) else $error("flash used for otp boot");
   property p_ram_order;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         ram_wr_o.we |-> ram_wr_o.addr == BLC_RAM_BASE + nwr;
   endproperty
   a_ram_order: assert property (p_ram_order) else $error("ram address out of order");
   property p_run_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         run_o |=> run_o && !boot_fail_o;
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("run dropped");
   property p_fail_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         boot_fail_o |=> boot_fail_o && !run_o;
   endproperty
   a_fail_hold: assert property (p_fail_hold) else $error("fail dropped or ran");
   property p_oe_cmd;
      @(posedge link_clk_i) disable iff (!rst_n_i)
         qspi_dq_oe_n_o != BLC_OE_N_IDLE |-> qspi_dq_oe_n_o == BLC_OE_N_CMD && !qspi_cs_n_o;
   endproperty
   a_oe_cmd: assert property (p_oe_cmd) else $error("flash pins driven wrongly");
endmodule : blc_loader_chk

bind blc_loader blc_loader_chk #(.OTP_AW(OTP_AW), .SEC_ROW(SEC_ROW), .INT_RESET_CYC(INT_RESET_CYC)) chk (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .otp_rd_o(otp_rd_o),
   .otp_addr_o(otp_addr_o), .ram_wr_o(ram_wr_o), .security_o(security_o), .run_o(run_o),
   .boot_fail_o(boot_fail_o), .gpio_pull_down_o(gpio_pull_down_o), .qspi_cs_n_o(qspi_cs_n_o),
   .qspi_dq_oe_n_o(qspi_dq_oe_n_o));

// *** test/blc_loader_bench.sv ***
// Bench for the boot image loader: OTP, RAM writes, flash on the link clock.
// Assumes blc_flash_model stands in for the quad-SPI flash.
`timescale 1ns/1ps
module blc_loader_bench;
   import blc_pkg::*;
   logic core_clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   // Board reset driver: low from power-up, supply taken as settled before time zero
   logic rst_n_i = 1'b0;
   logic otp_rd, run, fail, pull, cs_n, sclk;
   logic [10:0] otp_addr;
   logic [31:0] otp_mem [0:2047];
   logic [31:0] security;
   blc_ram_wr_t ram_wr;
   logic [3:0] dq_o, oe_n, dq_flash, dq_line;
   logic [7:0] img [$];
   logic [31:0] exp_q [$];
   int n_fail = 0;
   int checks = 0;
   always #25 core_clk_i = ~core_clk_i;
   initial begin
      #13;
      forever #62.5 link_clk_i = ~link_clk_i;
   end
   assign dq_line = (~oe_n & dq_o) | (oe_n & dq_flash);
   blc_loader DUT (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .otp_rd_o(otp_rd),
      .otp_addr_o(otp_addr), .otp_data_i(otp_mem[otp_addr]), .ram_wr_o(ram_wr), .security_o(security),
      .run_o(run), .boot_fail_o(fail), .gpio_pull_down_o(pull), .qspi_cs_n_o(cs_n), .qspi_sclk_o(sclk),
      .qspi_dq_o(dq_o), .qspi_dq_oe_n_o(oe_n), .qspi_dq_i(dq_line));
   blc_flash_model flash (.cs_n_i(cs_n), .sclk_i(sclk), .dq0_i(dq_line[0]), .dq_o(dq_flash));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   // Each RAM write takes the oldest expected write off the queue
   always @(posedge core_clk_i) begin
      if (ram_wr.we === 1'b1) begin
         if (exp_q.size() == 0) check("ram_wr_extra", 32'h0, 32'h1);
         else check("ram_wr", exp_q.pop_front(), {7'h00, ram_wr.addr, ram_wr.data});
      end
   end
   task automatic run_boot(input logic otp_src, input int words, input int mode);
      logic [31:0] crc;
      logic [31:0] sec;
      int k;
      int len;
      img.delete();
      exp_q.delete();
      len = (mode == 3) ? 32'h00008001 : words;
      for (k = 0; k < 4; k++) img.push_back(8'(len >> (8 * k)));
      for (k = 0; k < 4 * words; k++) begin
         img.push_back(8'($urandom));
         exp_q.push_back({7'h00, BLC_RAM_BASE + 17'(k), img[k + 4]});
      end
      crc = BLC_CRC_INIT;
      foreach (img[i]) begin
         crc = crc ^ 32'(img[i]);
         for (k = 0; k < 8; k++) crc = crc[0] ? (crc >> 1) ^ BLC_CRC_POLY : crc >> 1;
      end
      crc = (mode == 0) ? ~crc : (mode == 1) ? BLC_CRC_BYPASS : crc;
      for (k = 0; k < 4; k++) img.push_back(crc[8 * k +: 8]);
      foreach (otp_mem[i]) otp_mem[i] = 32'h0;
      foreach (img[i]) begin
         otp_mem[i / 4][8 * (i % 4) +: 8] = img[i];
         flash.img[i] = img[i];
      end
      sec = $urandom;
      sec[BLC_SEC_BOOT_BIT] = otp_src;
      otp_mem[11'h7FF] = sec;
      @(posedge core_clk_i);
      #2 rst_n_i = 1'b0;
      repeat (6) @(posedge core_clk_i);
      check("pull_down", 32'h1, 32'(pull));
      #2 rst_n_i = 1'b1;
      for (k = 0; k < 5000; k++) begin
         if (run === 1'b1 || fail === 1'b1) break;
         @(posedge core_clk_i);
      end
      if (k == 5000) begin
         check("done", 32'h1, 32'h0);
         return;
      end
      repeat (4) @(posedge core_clk_i);
      check("run", 32'(mode < 2), 32'(run));
      check("boot_fail", 32'(mode >= 2), 32'(fail));
      check("ram_left", 32'h0, 32'(exp_q.size()));
      check("security", sec, security);
      if (!otp_src) check("flash_header", {BLC_QSPI_CMD, BLC_QSPI_ADDR}, flash.hdr);
   endtask : run_boot
   initial begin
      void'($urandom(15));
      repeat (2) @(posedge core_clk_i);
      #2 rst_n_i = 1'b1;
      run_boot(1'b0, 3, 0);
      run_boot(1'b0, 0, 1);
      run_boot(1'b0, 2, 2);
      run_boot(1'b0, 0, 3);
      run_boot(1'b1, 4, 0);
      run_boot(1'b1, 1, 1);
      give_verdict();
   end
endmodule : blc_loader_bench
